// ===== hw/pmpu_entry_match.sv
// Address matcher for one protection entry, in four-byte word units
module pmpu_entry_match import pmpu_pkg::*; #(
	parameter int AW = 54
) (
	input wire logic enable_i,
	input wire logic [1:0] mode_i,
	input wire logic [AW-1:0] base_i,
	input wire logic [AW-1:0] top_i,
	input wire logic [AW-1:0] lo_word_i,
	input wire logic [AW-1:0] hi_word_i,
	output logic any_o,
	output logic all_o
);

	logic lo_in;
	logic hi_in;
	logic [AW-1:0] ign_mask;

	// Trailing ones of the address register plus one more bit are ignored
	assign ign_mask = top_i ^ (top_i + {{(AW-1){1'b0}}, 1'b1});

	function automatic logic in_region(input logic [AW-1:0] w);
		logic r;
		r = 1'b0;
		unique case (pmpu_mode_t'(mode_i))
			PMPU_MODE_OFF: r = 1'b0;
			PMPU_MODE_TOP_OF_RANGE: r = (w >= base_i) && (w < top_i);
			PMPU_MODE_ALIGNED_FOUR_BYTE: r = (w == top_i);
			PMPU_MODE_ALIGNED_POW2: r = ((w ^ top_i) & ~ign_mask) == '0;
		endcase
		return r;
	endfunction

	// Aligned accesses span at most two words and regions are contiguous, so
	// testing both end words covers any and all bytes
	always_comb begin
		lo_in = in_region(lo_word_i);
		hi_in = in_region(hi_word_i);
		any_o = enable_i && (lo_in || hi_in);
		all_o = enable_i && lo_in && hi_in;
	end

endmodule

// ===== hw/pmpu_unit.sv
// Physical memory protection checker with its machine-mode registers
`include "pmpu_map.svh"

module pmpu_unit import pmpu_pkg::*; #(
	parameter int N_ENTRIES = 16
) (
	input wire logic ref_clk_i,
	input wire logic rst_i,
	input wire logic machine_register_width_is64_i,
	input wire logic csr_valid_i,
	input wire logic csr_write_i,
	input wire logic [11:0] csr_addr_i,
	input wire logic [63:0] csr_wdata_i,
	input wire logic [1:0] csr_priv_i,
	output logic csr_done_o,
	output logic csr_illegal_o,
	output logic [63:0] csr_rdata_o,
	input wire logic chk_valid_i,
	input wire logic [55:0] chk_addr_i,
	input wire logic [1:0] chk_size_i,
	input wire logic [1:0] chk_kind_i,
	input wire logic [1:0] chk_priv_i,
	input wire logic modify_privilege_bit_i,
	input wire logic [1:0] previous_privilege_field_i,
	input wire logic chk_page_walk_i,
	input wire logic chk_speculative_i,
	input wire logic chk_redundant_i,
	input wire logic attr_io_region_i,
	input wire logic attr_read_idem_i,
	input wire logic attr_write_idem_i,
	output logic chk_done_o,
	output logic chk_grant_o,
	output logic chk_fault_o,
	output logic [1:0] chk_cause_o,
	output logic chk_defer_o,
	output logic chk_misaligned_o
);

	localparam int N_MAX = 16;
	localparam int AW = 54;

	logic [7:0] cfg_q [N_MAX];
	logic [AW-1:0] addr_q [N_MAX];
	logic [N_MAX-1:0] cfg_we;
	logic [N_MAX-1:0] addr_we;
	logic [7:0] next_cfg [N_MAX];
	logic [AW-1:0] next_addr;
	logic is_cfg;
	logic is_addr;
	logic csr_bad;
	logic [63:0] csr_read;
	logic [N_MAX-1:0] ent_any;
	logic [N_MAX-1:0] ent_all;
	logic [55:0] hi_byte;
	logic [2:0] size_m1;
	pmpu_priv_t eff_priv;
	logic hit;
	logic hit_all;
	logic [7:0] hit_cfg;
	logic perm;
	logic prot_fail;
	logic non_idem;
	logic misal;

	// Legalise a config byte: reserved bits zero, write needs read
	function automatic logic [7:0] cfg_legal(input logic [7:0] b);
		logic [7:0] r;
		r = b & `PMPU_CFG_WR_MASK;
		if (!r[`PMPU_CFG_READ_BIT]) begin
			r[`PMPU_CFG_WRITE_BIT] = 1'b0;
		end
		return r;
	endfunction

	// Position of an entry's byte in a config register for the width
	function automatic logic [3:0] cfg_reg_of(input int e, input logic w64);
		logic [3:0] r;
		r = w64 ? ((e < 8) ? 4'h0 : 4'h2) : 4'(e / 4);
		return r;
	endfunction

	function automatic int cfg_lane_of(input int e, input logic w64);
		return w64 ? (e % 8) : (e % 4);
	endfunction

	function automatic logic locked(input int e);
		return cfg_q[e][`PMPU_CFG_LOCK_BIT];
	endfunction

	// Register port decode
	always_comb begin
		is_cfg = (csr_addr_i & `PMPU_CSR_CFG_MASK) == `PMPU_CSR_CFG_BASE;
		is_addr = (csr_addr_i & `PMPU_CSR_ADDR_MASK) == `PMPU_CSR_ADDR_BASE;
		csr_bad = (pmpu_priv_t'(csr_priv_i) != PMPU_PRIV_M)
			|| !(is_cfg || is_addr)
			|| (is_cfg && machine_register_width_is64_i
			&& csr_addr_i[0]);
	end

	// Write enables; locked entries and bytes of absent entries hold still
	always_comb begin
		next_addr = machine_register_width_is64_i ? csr_wdata_i[AW-1:0]
			: {22'h0, csr_wdata_i[31:0]};
		for (int e = 0; e < N_MAX; e++) begin
			next_cfg[e] = cfg_legal(csr_wdata_i[8 *
				cfg_lane_of(e, machine_register_width_is64_i) +: 8]);
			cfg_we[e] = csr_valid_i && csr_write_i && !csr_bad && is_cfg
				&& (e < N_ENTRIES)
				&& (csr_addr_i[3:0] == {2'h0, csr_addr_i[1:0]})
				&& (cfg_reg_of(e, machine_register_width_is64_i)
				== {2'h0, csr_addr_i[1:0]})
				&& !locked(e);
			addr_we[e] = csr_valid_i && csr_write_i && !csr_bad && is_addr
				&& (e < N_ENTRIES)
				&& (csr_addr_i[3:0] == 4'(e))
				&& !locked(e);
			if (e < N_MAX - 1) begin
				// Locked top-of-range entry also freezes its lower bound
				if (locked(e + 1) && (pmpu_mode_t'(cfg_q[e + 1][4:3])
					== PMPU_MODE_TOP_OF_RANGE)) begin
					addr_we[e] = 1'b0;
				end
			end
		end
	end

	// Config storage; locked bytes are cleared only by system reset
	always_ff @(posedge ref_clk_i or posedge rst_i) begin
		if (rst_i) begin
			for (int e = 0; e < N_MAX; e++) begin
				cfg_q[e] <= `PMPU_CFG_RESET;
			end
		end else begin
			for (int e = 0; e < N_MAX; e++) begin
				if (cfg_we[e]) begin
					cfg_q[e] <= next_cfg[e];
				end
			end
		end
	end

	// Address storage
	always_ff @(posedge ref_clk_i or posedge rst_i) begin
		if (rst_i) begin
			for (int e = 0; e < N_MAX; e++) begin
				addr_q[e] <= `PMPU_ADDR_RESET;
			end
		end else begin
			for (int e = 0; e < N_MAX; e++) begin
				if (addr_we[e]) begin
					addr_q[e] <= next_addr;
				end
			end
		end
	end

	// Read mux; bytes land where the current width packs them
	always_comb begin
		csr_read = 64'h0;
		if (is_cfg) begin
			for (int e = 0; e < N_MAX; e++) begin
				if (cfg_reg_of(e, machine_register_width_is64_i)
					== {2'h0, csr_addr_i[1:0]}) begin
					csr_read[8 * cfg_lane_of(e,
						machine_register_width_is64_i) +: 8]
						= cfg_q[e];
				end
			end
		end else if (is_addr) begin
			csr_read = machine_register_width_is64_i
				? {10'h0, addr_q[csr_addr_i[3:0]]}
				: {32'h0, addr_q[csr_addr_i[3:0]][31:0]};
		end
	end

	// Register port answer, one cycle after the request
	always_ff @(posedge ref_clk_i or posedge rst_i) begin
		if (rst_i) begin
			csr_done_o <= 1'b0;
			csr_illegal_o <= 1'b0;
			csr_rdata_o <= 64'h0;
		end else begin
			csr_done_o <= csr_valid_i;
			csr_illegal_o <= csr_valid_i && csr_bad;
			csr_rdata_o <= (csr_valid_i && !csr_bad) ? csr_read : 64'h0;
		end
	end

	// Byte span of the access
	always_comb begin
		unique case (chk_size_i)
			2'h0: size_m1 = 3'h0;
			2'h1: size_m1 = 3'h1;
			2'h2: size_m1 = 3'h3;
			2'h3: size_m1 = 3'h7;
		endcase
		hi_byte = chk_addr_i + {53'h0, size_m1};
		misal = (chk_addr_i[2:0] & size_m1) != 3'h0;
	end

	// One matcher per entry, all evaluated in parallel
	for (genvar g = 0; g < N_MAX; g++) begin : g_ent
		pmpu_entry_match #(
			.AW(AW)
		) u_match (
			.enable_i(g < N_ENTRIES),
			.mode_i(cfg_q[g][`PMPU_CFG_MODE_HI:`PMPU_CFG_MODE_LO]),
			.base_i((g == 0) ? {AW{1'b0}} : addr_q[(g == 0) ? 0 : g - 1]),
			.top_i(addr_q[g]),
			.lo_word_i(chk_addr_i[55:2]),
			.hi_word_i(hi_byte[55:2]),
			.any_o(ent_any[g]),
			.all_o(ent_all[g])
		);
	end

	// Effective privilege of the access
	always_comb begin
		if (chk_page_walk_i) begin
			eff_priv = PMPU_PRIV_S;
		end else if (modify_privilege_bit_i
			&& (pmpu_priv_t'(chk_priv_i) == PMPU_PRIV_M)
			&& (pmpu_kind_t'(chk_kind_i) != PMPU_KIND_FETCH)) begin
			// Only machine mode may borrow a privilege; S/U keep their own
			eff_priv = pmpu_priv_t'(previous_privilege_field_i);
		end else begin
			eff_priv = pmpu_priv_t'(chk_priv_i);
		end
	end

	// Static priority: walk down so the lowest matching entry wins
	always_comb begin
		hit = 1'b0;
		hit_all = 1'b0;
		hit_cfg = 8'h00;
		for (int e = N_MAX - 1; e >= 0; e--) begin
			if (ent_any[e]) begin
				hit = 1'b1;
				hit_all = ent_all[e];
				hit_cfg = cfg_q[e];
			end
		end
	end

	// Permission decision
	always_comb begin
		unique case (pmpu_kind_t'(chk_kind_i))
			PMPU_KIND_FETCH: perm = hit_cfg[`PMPU_CFG_EXEC_BIT];
			PMPU_KIND_LOAD: perm = hit_cfg[`PMPU_CFG_READ_BIT];
			PMPU_KIND_STORE: perm = hit_cfg[`PMPU_CFG_WRITE_BIT];
			default: perm = 1'b0;
		endcase
		if (!hit) begin
			prot_fail = (eff_priv != PMPU_PRIV_M) && (N_ENTRIES > 0);
		end else if (!hit_all) begin
			prot_fail = 1'b1;
		end else if (eff_priv == PMPU_PRIV_M
			&& !hit_cfg[`PMPU_CFG_LOCK_BIT]) begin
			prot_fail = 1'b0;
		end else begin
			prot_fail = !perm;
		end
	end

	// Idempotency from the attribute check of the same access
	always_comb begin
		if (!attr_io_region_i) begin
			non_idem = 1'b0;
		end else if (pmpu_kind_t'(chk_kind_i) == PMPU_KIND_STORE) begin
			non_idem = !attr_write_idem_i;
		end else begin
			non_idem = !attr_read_idem_i;
		end
	end

	// Result register; attribute and permission resolve in one cycle.
	// Only grant lets the pipeline issue, so a fault leaves no trace.
	always_ff @(posedge ref_clk_i or posedge rst_i) begin
		if (rst_i) begin
			chk_done_o <= 1'b0;
			chk_grant_o <= 1'b0;
			chk_fault_o <= 1'b0;
			chk_cause_o <= PMPU_CAUSE_NONE;
			chk_defer_o <= 1'b0;
			chk_misaligned_o <= 1'b0;
		end else begin
			chk_done_o <= chk_valid_i;
			chk_grant_o <= 1'b0;
			chk_fault_o <= 1'b0;
			chk_cause_o <= PMPU_CAUSE_NONE;
			chk_defer_o <= 1'b0;
			chk_misaligned_o <= 1'b0;
			if (chk_valid_i) begin
				if (prot_fail || (misal && non_idem)) begin
					chk_fault_o <= 1'b1;
					unique case (pmpu_kind_t'(chk_kind_i))
						PMPU_KIND_FETCH: chk_cause_o <= PMPU_CAUSE_FETCH;
						PMPU_KIND_LOAD: chk_cause_o <= PMPU_CAUSE_LOAD;
						default: chk_cause_o <= PMPU_CAUSE_STORE;
					endcase
				end else if (misal) begin
					chk_misaligned_o <= 1'b1;
				end else if (non_idem
					&& (chk_speculative_i || chk_redundant_i)) begin
					chk_defer_o <= 1'b1;
				end else begin
					chk_grant_o <= 1'b1;
				end
			end
		end
	end

endmodule

// ===== include/pmpu_map.svh
// Register numbers, configuration field positions and reset values
`ifndef PMPU_MAP_SVH
`define PMPU_MAP_SVH

// Control register numbers on the register port
`define PMPU_CSR_CFG_BASE 12'h3A0
`define PMPU_CSR_CFG_MASK 12'hFFC
`define PMPU_CSR_ADDR_BASE 12'h3B0
`define PMPU_CSR_ADDR_MASK 12'hFF0

// Configuration byte layout
`define PMPU_CFG_READ_BIT 0
`define PMPU_CFG_WRITE_BIT 1
`define PMPU_CFG_EXEC_BIT 2
`define PMPU_CFG_MODE_LO 3
`define PMPU_CFG_MODE_HI 4
`define PMPU_CFG_LOCK_BIT 7
`define PMPU_CFG_WR_MASK 8'h9F

// Reset values
`define PMPU_CFG_RESET 8'h00
`define PMPU_ADDR_RESET 54'h0

`endif

// ===== include/pmpu_pkg.sv
// Types shared by the protection unit and its entry matcher
package pmpu_pkg;

	typedef enum logic [1:0] {
		PMPU_PRIV_U = 2'h0,
		PMPU_PRIV_S = 2'h1,
		PMPU_PRIV_R = 2'h2,
		PMPU_PRIV_M = 2'h3
	} pmpu_priv_t;

	typedef enum logic [1:0] {
		PMPU_KIND_FETCH = 2'h0,
		PMPU_KIND_LOAD = 2'h1,
		PMPU_KIND_STORE = 2'h2,
		PMPU_KIND_RSVD = 2'h3
	} pmpu_kind_t;

	typedef enum logic [1:0] {
		PMPU_MODE_OFF = 2'h0,
		PMPU_MODE_TOP_OF_RANGE = 2'h1,
		PMPU_MODE_ALIGNED_FOUR_BYTE = 2'h2,
		PMPU_MODE_ALIGNED_POW2 = 2'h3
	} pmpu_mode_t;

	typedef enum logic [1:0] {
		PMPU_CAUSE_NONE = 2'h0,
		PMPU_CAUSE_FETCH = 2'h1,
		PMPU_CAUSE_LOAD = 2'h2,
		PMPU_CAUSE_STORE = 2'h3
	} pmpu_cause_t;

endpackage

// ===== sim/pmpu_attr_model.sv
// Attribute source standing beside the pipeline for the checker
module pmpu_attr_model (
	input wire logic [55:0] addr_i,
	output logic io_o,
	output logic rd_idem_o,
	output logic wr_idem_o
);
	timeunit 1ns;
	timeprecision 1ns;
	// 0x1800-0x1FFF repeats reads but not writes
	// 0x3000-0x3FFF must never be touched twice
	// Combinational, so it lands with the permission
	always_comb begin
		io_o = addr_i[55:11] == 45'h3 || addr_i[55:12] == 44'h3;
		rd_idem_o = addr_i[55:11] == 45'h3;
		wr_idem_o = 1'b0;
	end
endmodule

// ===== sim/pmpu_unit_props.sv
// Port checker for the protection unit
module pmpu_unit_props (
	input wire logic ref_clk_i,
	input wire logic rst_i,
	input wire logic machine_register_width_is64_i,
	input wire logic csr_valid_i,
	input wire logic [11:0] csr_addr_i,
	input wire logic [1:0] csr_priv_i,
	input wire logic csr_done_o,
	input wire logic csr_illegal_o,
	input wire logic [63:0] csr_rdata_o,
	input wire logic chk_valid_i,
	input wire logic [1:0] chk_kind_i,
	input wire logic chk_speculative_i,
	input wire logic chk_redundant_i,
	input wire logic attr_io_region_i,
	input wire logic attr_read_idem_i,
	input wire logic attr_write_idem_i,
	input wire logic chk_done_o,
	input wire logic chk_grant_o,
	input wire logic chk_fault_o,
	input wire logic [1:0] chk_cause_o,
	input wire logic chk_defer_o,
	input wire logic chk_misaligned_o
);
	timeunit 1ns;
	timeprecision 1ns;
	default clocking @(posedge ref_clk_i); endclocking
	default disable iff (rst_i);
	logic non_idem;
	// Stores follow the write attribute, all else the read one
	assign non_idem = attr_io_region_i &&
		!(chk_kind_i == 2'h2 ? attr_write_idem_i : attr_read_idem_i);
	// Register port answers
	csr_answer_a: assert property (
		csr_valid_i |=> csr_done_o) else $error("no register answer");
	csr_quiet_a: assert property (
		!csr_valid_i |=> !csr_done_o && !csr_illegal_o)
		else $error("stray register answer");
	low_priv_a: assert property (
		csr_valid_i && csr_priv_i != 2'h3 |=>
		csr_illegal_o && csr_rdata_o == 64'h0)
		else $error("low privilege access taken");
	odd_cfg64_a: assert property (
		csr_valid_i && machine_register_width_is64_i && csr_addr_i[0] &&
		csr_addr_i[11:2] == 10'h0E8 |=> csr_illegal_o)
		else $error("odd config word taken in wide mode");
	// Check port answers
	chk_answer_a: assert property (
		chk_valid_i |=> chk_done_o) else $error("no check answer");
	one_result_a: assert property (
		chk_done_o |-> $onehot({chk_grant_o, chk_fault_o, chk_defer_o,
		chk_misaligned_o})) else $error("not one result");
	cause_link_a: assert property (
		chk_done_o |-> chk_fault_o == (chk_cause_o != 2'h0))
		else $error("cause and fault disagree");
	no_spec_a: assert property (
		chk_valid_i && non_idem && (chk_speculative_i || chk_redundant_i)
		|=> !chk_grant_o) else $error("speculative access granted");
	main_idem_a: assert property (
		chk_valid_i && !attr_io_region_i |=> !chk_defer_o)
		else $error("main memory deferred");
	nonidem_mis_a: assert property (
		chk_valid_i && non_idem |=> !chk_misaligned_o)
		else $error("misaligned raised on side effect region");
	cover property (chk_valid_i ##1 chk_defer_o);
	cover property (chk_valid_i ##1 chk_misaligned_o);
	cover property (csr_valid_i ##1 csr_illegal_o);
endmodule

// ===== sim/tb_top.sv
// Testbench: register and check sequences against the protection unit
module tb_top;
	timeunit 1ns;
	timeprecision 1ns;
	localparam logic [5:0] gr = 6'h20, f_x = 6'h11, f_ld = 6'h12;
	localparam logic [5:0] f_st = 6'h13, df = 6'h08, ms = 6'h04;
	logic ref_clk_i = 1'b0;
	logic rst_i = 1'b1;
	logic machine_register_width_is64_i = 1'b0;
	logic csr_valid_i = 1'b0, csr_write_i = 1'b0, chk_valid_i = 1'b0;
	logic [11:0] csr_addr_i = 12'h000;
	logic [63:0] csr_wdata_i = 64'h0, csr_rdata_o;
	logic [1:0] csr_priv_i = 2'h0, chk_size_i = 2'h0, chk_kind_i = 2'h0;
	logic [1:0] chk_priv_i = 2'h0, previous_privilege_field_i = 2'h0;
	logic modify_privilege_bit_i = 1'b0, chk_page_walk_i = 1'b0;
	logic chk_speculative_i = 1'b0, chk_redundant_i = 1'b0;
	logic [55:0] chk_addr_i = 56'h0;
	logic attr_io_region_i, attr_read_idem_i, attr_write_idem_i;
	logic csr_done_o, csr_illegal_o, chk_done_o, chk_grant_o, chk_fault_o;
	logic chk_defer_o, chk_misaligned_o;
	logic [1:0] chk_cause_o;
	int num_errors = 0, compares = 0, cyc = 0;

	pmpu_unit dut (.ref_clk_i, .rst_i, .machine_register_width_is64_i,
		.csr_valid_i, .csr_write_i, .csr_addr_i, .csr_wdata_i, .csr_priv_i,
		.csr_done_o, .csr_illegal_o, .csr_rdata_o, .chk_valid_i, .chk_addr_i,
		.chk_size_i, .chk_kind_i, .chk_priv_i, .modify_privilege_bit_i,
		.previous_privilege_field_i, .chk_page_walk_i, .chk_speculative_i,
		.chk_redundant_i, .attr_io_region_i, .attr_read_idem_i,
		.attr_write_idem_i, .chk_done_o, .chk_grant_o, .chk_fault_o,
		.chk_cause_o, .chk_defer_o, .chk_misaligned_o);
	pmpu_attr_model hart_attr (.addr_i(chk_addr_i), .io_o(attr_io_region_i),
		.rd_idem_o(attr_read_idem_i), .wr_idem_o(attr_write_idem_i));

	always #20 ref_clk_i = ~ref_clk_i;

	// Hang guard, well above the hundred or so cycles the run needs
	always @(posedge ref_clk_i) begin
		cyc <= cyc + 1;
		if (cyc == 1000) begin
			num_errors++;
			print_verdict();
		end
	end

	task automatic print_verdict();
		if (num_errors == 0 && compares > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask

	task automatic cmp(input string n, input logic [65:0] e, g);
		compares++;
		if (g !== e) begin
			num_errors++;
			$display("ERROR %s exp %h got %h", n, e, g);
		end
	endtask

	// One register request, answer sampled on the next edge
	task automatic acc(input logic w, input logic [11:0] a,
		input logic [63:0] d, input logic [1:0] p, input logic il,
		input logic [63:0] e);
		@(posedge ref_clk_i);
		#1;
		{csr_valid_i, csr_write_i, csr_addr_i, csr_wdata_i} = {1'b1, w, a, d};
		csr_priv_i = p;
		@(posedge ref_clk_i);
		#1;
		csr_valid_i = 1'b0;
		cmp("register", {1'b1, il, e}, {csr_done_o, csr_illegal_o, csr_rdata_o});
	endtask

	task automatic rd(input logic [11:0] a, input logic [63:0] e);
		acc(1'b0, a, 64'h0, 2'h3, 1'b0, e);
	endtask

	task automatic wr(input logic [11:0] a, input logic [63:0] d, old);
		acc(1'b1, a, d, 2'h3, 1'b0, old);
	endtask

	// Side qualifiers: modify bit, previous field, walk, spec, replay
	task automatic side(input logic [5:0] m);
		{modify_privilege_bit_i, previous_privilege_field_i, chk_page_walk_i,
			chk_speculative_i, chk_redundant_i} = m;
	endtask

	task automatic chk(input logic [55:0] a, input logic [1:0] s, k, p,
		input logic [5:0] e);
		@(posedge ref_clk_i);
		#1;
		{chk_valid_i, chk_addr_i, chk_size_i, chk_kind_i} = {1'b1, a, s, k};
		chk_priv_i = p;
		@(posedge ref_clk_i);
		#1;
		chk_valid_i = 1'b0;
		cmp("check", {59'h0, 1'b1, e}, {59'h0, chk_done_o, chk_grant_o,
			chk_fault_o, chk_defer_o, chk_misaligned_o, chk_cause_o});
	endtask

	initial begin
		repeat (3) @(posedge ref_clk_i);
		#1 rst_i = 1'b0;
		chk(56'h1000, 2'h2, 2'h1, 2'h0, f_ld);
		chk(56'h1000, 2'h2, 2'h1, 2'h3, gr);
		rd(12'h3A0, 64'h0);
		acc(1'b0, 12'h3A0, 64'h0, 2'h1, 1'b1, 64'h0);
		acc(1'b1, 12'h3A0, 64'h13, 2'h0, 1'b1, 64'h0);
		acc(1'b0, 12'h3C0, 64'h0, 2'h3, 1'b1, 64'h0);
		wr(12'h3A0, 64'h6A, 64'h0);
		rd(12'h3A0, 64'h08);
		wr(12'h3B0, 64'h400, 64'h0);
		wr(12'h3B1, 64'h800, 64'h0);
		wr(12'h3B2, 64'hC01, 64'h0);
		wr(12'h3A0, 64'h00190F13, 64'h08);
		rd(12'h3A0, 64'h00190F13);
		chk(56'h1000, 2'h2, 2'h1, 2'h0, gr);
		chk(56'h1000, 2'h2, 2'h2, 2'h0, gr);
		chk(56'h1000, 2'h2, 2'h0, 2'h0, f_x);
		chk(56'h1800, 2'h2, 2'h2, 2'h1, gr);
		chk(56'h0FFC, 2'h2, 2'h1, 2'h1, f_ld);
		chk(56'h1002, 2'h2, 2'h1, 2'h0, f_ld);
		chk(56'h1000, 2'h3, 2'h1, 2'h0, f_ld);
		chk(56'h1003, 2'h0, 2'h1, 2'h0, gr);
		chk(56'h1001, 2'h1, 2'h1, 2'h0, ms);
		chk(56'h1000, 2'h2, 2'h3, 2'h0, f_st);
		chk(56'h300C, 2'h2, 2'h1, 2'h0, gr);
		chk(56'h3008, 2'h2, 2'h2, 2'h0, f_st);
		chk(56'h3010, 2'h2, 2'h1, 2'h0, f_ld);
		chk(56'h3008, 2'h2, 2'h2, 2'h3, gr);
		side(6'h20);
		chk(56'h3008, 2'h2, 2'h2, 2'h3, f_st);
		chk(56'h3010, 2'h2, 2'h0, 2'h3, gr);
		side(6'h38);
		chk(56'h3008, 2'h2, 2'h2, 2'h3, gr);
		chk(56'h3010, 2'h2, 2'h1, 2'h0, f_ld);
		side(6'h04);
		chk(56'h3010, 2'h2, 2'h1, 2'h3, f_ld);
		side(6'h02);
		chk(56'h3000, 2'h2, 2'h1, 2'h0, df);
		chk(56'h1800, 2'h2, 2'h1, 2'h0, gr);
		chk(56'h1800, 2'h2, 2'h2, 2'h0, df);
		chk(56'h1000, 2'h2, 2'h2, 2'h0, gr);
		side(6'h01);
		chk(56'h3004, 2'h2, 2'h1, 2'h0, df);
		side(6'h00);
		chk(56'h3002, 2'h2, 2'h1, 2'h0, f_ld);
		chk(56'h1802, 2'h2, 2'h1, 2'h0, ms);
		wr(12'h3A0, 64'h00190F93, 64'h00190F13);
		chk(56'h1000, 2'h2, 2'h2, 2'h3, gr);
		chk(56'h1000, 2'h2, 2'h0, 2'h3, f_x);
		wr(12'h3A0, 64'h0, 64'h00190F93);
		rd(12'h3A0, 64'h93);
		wr(12'h3B0, 64'h0, 64'h400);
		rd(12'h3B0, 64'h400);
		wr(12'h3A1, 64'h01030507, 64'h0);
		machine_register_width_is64_i = 1'b1;
		rd(12'h3A0, 64'h01030507_00000093);
		acc(1'b0, 12'h3A1, 64'h0, 2'h3, 1'b1, 64'h0);
		wr(12'h3A2, 64'h01000000_00000003, 64'h0);
		wr(12'h3B5, 64'hFFFFFFFF_FFFFFFFF, 64'h0);
		rd(12'h3B5, 64'h003FFFFF_FFFFFFFF);
		machine_register_width_is64_i = 1'b0;
		rd(12'h3A2, 64'h3);
		rd(12'h3A3, 64'h01000000);
		rd(12'h3B5, 64'hFFFFFFFF);
		rst_i = 1'b1;
		repeat (3) @(posedge ref_clk_i);
		#1 rst_i = 1'b0;
		rd(12'h3A0, 64'h0);
		print_verdict();
	end
endmodule

bind pmpu_unit pmpu_unit_props props (.ref_clk_i, .rst_i,
	.machine_register_width_is64_i, .csr_valid_i, .csr_addr_i, .csr_priv_i,
	.csr_done_o, .csr_illegal_o, .csr_rdata_o, .chk_valid_i, .chk_kind_i,
	.chk_speculative_i, .chk_redundant_i, .attr_io_region_i,
	.attr_read_idem_i, .attr_write_idem_i, .chk_done_o, .chk_grant_o,
	.chk_fault_o, .chk_cause_o, .chk_defer_o, .chk_misaligned_o);
